// *** core/dcq_dual_clock_queue.v ***
// Queue with empty, full and watermark flags, registers on classic Wishbone.
// Assumes push and pop users run on clk_i; reset rst_i is synchronous, active high.
`timescale 1ns/100ps
`include "dcq_defines.vh"

module dcq_dual_clock_queue #(
    parameter DW = 8,
    parameter AW = 4,
    parameter OUT_REG = 0,
    parameter [AW-1:0] FULL_LEVEL = {AW{1'b1}},
    parameter [AW-1:0] LOW_SINGLE = 1,
    parameter [AW-1:0] LOW_ASSERT = 1,
    parameter [AW-1:0] LOW_RELEASE = 3,
    parameter [AW-1:0] HIGH_SINGLE = {AW{1'b1}} - 1'b1,
    parameter [AW-1:0] HIGH_ASSERT = {AW{1'b1}} - 1'b1,
    parameter [AW-1:0] HIGH_RELEASE = {AW{1'b1}} - 2'd3
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Push side
    input wire push_enable_i,
    input wire [DW-1:0] push_data_i,
    // Pop side
    input wire pop_enable_i,
    input wire output_stage_enable_i,
    input wire retransmit_pointer_clear_i,
    output wire [DW-1:0] pop_data_o,
    // Run-time thresholds
    input wire [AW-1:0] low_water_single_level_i,
    input wire [AW-1:0] low_water_assert_level_i,
    input wire [AW-1:0] low_water_release_level_i,
    input wire [AW-1:0] high_water_single_level_i,
    input wire [AW-1:0] high_water_assert_level_i,
    input wire [AW-1:0] high_water_release_level_i,
    // Flags
    output wire empty_o,
    output wire low_water_o,
    output wire high_water_o,
    output wire full_o
);

    localparam DEPTH = 1 << AW;

    // Fill level between two pointers, one extra bit for wrap
    function [AW:0] fill;
        input [AW:0] wp;
        input [AW:0] rp;
        begin
            fill = wp - rp;
        end
    endfunction

    // Storage, never reset
    reg [DW-1:0] mem [0:DEPTH-1];

    // Pointers
    reg [AW:0] wptr_q;
    reg [AW:0] wcom_q;
    reg [AW:0] rptr_q;

    // Input register stage
    reg [DW-1:0] wdata_q;
    reg [AW-1:0] waddr_q;
    reg wstb_q;

    // No-data indication, write then read side
    reg nd_w_q;
    reg nd_r_q;

    // Flags
    reg empty_q;
    reg low_q;
    reg high_q;
    reg full_q;

    // Read data path
    reg [DW-1:0] rdata_q;
    reg [DW-1:0] out_q;

    // Bus registers
    reg [`DCQ_CTRL_W-1:0] ctrl_q;
    reg ack_q;
    reg [31:0] rdat_q;

    wire accept;
    wire rd_stb;
    wire [AW:0] lvl_w;
    wire [AW:0] lvl_r;
    wire [AW:0] lvl_w_d;
    wire [AW:0] lvl_r_d;
    wire [AW:0] lvl_r_pre;
    wire [AW:0] lo_single;
    wire [AW:0] lo_set;
    wire [AW:0] lo_clr;
    wire [AW:0] hi_single;
    wire [AW:0] hi_set;
    wire [AW:0] hi_clr;
    wire [AW:0] full_lvl;
    reg low_d;
    reg high_d;

    // Pushes while full are dropped
    assign accept = push_enable_i & ~full_q;

    // Storage read strobe gated by the no-data indication
    assign rd_stb = pop_enable_i & ~nd_r_q;

    // Write side counts accepted pushes, read side only committed words
    assign lvl_w = fill(wptr_q, rptr_q);
    assign lvl_r = fill(wcom_q, rptr_q);
    assign lvl_w_d = lvl_w + {{AW{1'b0}}, accept} - {{AW{1'b0}}, rd_stb};
    assign lvl_r_pre = retransmit_pointer_clear_i ? wcom_q : lvl_r;
    assign lvl_r_d = lvl_r_pre + {{AW{1'b0}}, wstb_q}
                     - {{AW{1'b0}}, rd_stb & ~retransmit_pointer_clear_i};

    // Threshold source: build-time values or ports
    assign lo_single = {1'b0, ctrl_q[`DCQ_CTRL_DYNAMIC] ? low_water_single_level_i : LOW_SINGLE};
    assign lo_set = {1'b0, ctrl_q[`DCQ_CTRL_DYNAMIC] ? low_water_assert_level_i : LOW_ASSERT};
    assign lo_clr = {1'b0, ctrl_q[`DCQ_CTRL_DYNAMIC] ? low_water_release_level_i : LOW_RELEASE};
    assign hi_single = {1'b0, ctrl_q[`DCQ_CTRL_DYNAMIC] ? high_water_single_level_i : HIGH_SINGLE};
    assign hi_set = {1'b0, ctrl_q[`DCQ_CTRL_DYNAMIC] ? high_water_assert_level_i : HIGH_ASSERT};
    assign hi_clr = {1'b0, ctrl_q[`DCQ_CTRL_DYNAMIC] ? high_water_release_level_i : HIGH_RELEASE};
    assign full_lvl = {1'b0, FULL_LEVEL};

    // Watermark next values, absolute levels
    always @* begin
        low_d = low_q;
        if (!ctrl_q[`DCQ_CTRL_LOW_DUAL]) begin
            low_d = (lvl_r_d <= lo_single);
        end else if (lvl_r_d <= lo_set) begin
            low_d = 1'b1;
        end else if (lvl_r_d >= lo_clr) begin
            low_d = 1'b0;
        end
    end

    always @* begin
        high_d = high_q;
        if (!ctrl_q[`DCQ_CTRL_HIGH_DUAL]) begin
            high_d = (lvl_w_d >= hi_single);
        end else if (lvl_w_d >= hi_set) begin
            high_d = 1'b1;
        end else if (lvl_w_d <= hi_clr) begin
            high_d = 1'b0;
        end
    end

    // Input register, not touched by reset
    always @(posedge clk_i) begin
        if (accept) begin
            wdata_q <= push_data_i;
            waddr_q <= wptr_q[AW-1:0];
        end
    end

    // Storage write one cycle after acceptance
    always @(posedge clk_i) begin
        if (wstb_q) begin
            mem[waddr_q] <= wdata_q;
        end
    end

    // Write side pointer logic
    always @(posedge clk_i) begin
        if (rst_i) begin
            wptr_q <= {(AW+1){1'b0}};
            wcom_q <= {(AW+1){1'b0}};
            wstb_q <= 1'b0;
        end else begin
            wstb_q <= accept;
            if (accept) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (wstb_q) begin
                wcom_q <= wcom_q + 1'b1;
            end
        end
    end

    // No-data indication: write side stage enabled by push
    always @(posedge clk_i) begin
        if (rst_i) begin
            nd_w_q <= 1'b1;
        end else if (push_enable_i) begin
            nd_w_q <= ~accept & (lvl_r == `DCQ_EMPTY_LEVEL);
        end
    end

    // Second stage on the read side, enabled by pop; costs one extra pop cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            nd_r_q <= 1'b1;
        end else if (pop_enable_i) begin
            nd_r_q <= nd_w_q | (lvl_r_d == `DCQ_EMPTY_LEVEL);
        end
    end

    // Read pointer; retransmit clear zeroes it, leaves the write pointers, and wins over a read strobe
    always @(posedge clk_i) begin
        if (rst_i) begin
            rptr_q <= {(AW+1){1'b0}};
        end else if (retransmit_pointer_clear_i) begin
            rptr_q <= {(AW+1){1'b0}};
        end else if (rd_stb) begin
            rptr_q <= rptr_q + 1'b1;
        end
    end

    // Storage read register, not reset like the array itself
    always @(posedge clk_i) begin
        if (rd_stb && !retransmit_pointer_clear_i) begin
            rdata_q <= mem[rptr_q[AW-1:0]];
        end
    end

    // Optional output stage adds one pop cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= {DW{1'b0}};
        end else if (output_stage_enable_i) begin
            out_q <= rdata_q;
        end
    end

    assign pop_data_o = (OUT_REG != 0) ? out_q : rdata_q;

    // Read side flags, settle one cycle after retransmit clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            empty_q <= 1'b1;
            low_q <= 1'b1;
        end else begin
            empty_q <= (lvl_r_d == `DCQ_EMPTY_LEVEL);
            low_q <= low_d;
        end
    end

    // Write side flags
    always @(posedge clk_i) begin
        if (rst_i) begin
            full_q <= 1'b0;
            high_q <= 1'b0;
        end else begin
            full_q <= (lvl_w_d >= full_lvl);
            high_q <= high_d;
        end
    end

    assign empty_o = empty_q;
    assign low_water_o = low_q;
    assign high_water_o = high_q;
    assign full_o = full_q;

    // Wishbone slave: one wait state, ack dropped after one cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `DCQ_CTRL_RST;
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
            if (wb_cyc_i && wb_stb_i && !ack_q) begin
                rdat_q <= 32'h00000000;
                if (wb_adr_i == `DCQ_CTRL_OFS) begin
                    if (wb_we_i && wb_sel_i[0]) begin
                        ctrl_q <= wb_dat_i[`DCQ_CTRL_W-1:0];
                    end
                    rdat_q[`DCQ_CTRL_W-1:0] <= ctrl_q;
                end else if (wb_adr_i == `DCQ_STAT_OFS) begin
                    rdat_q[`DCQ_STAT_EMPTY] <= empty_q;
                    rdat_q[`DCQ_STAT_LOW] <= low_q;
                    rdat_q[`DCQ_STAT_HIGH] <= high_q;
                    rdat_q[`DCQ_STAT_FULL] <= full_q;
                    rdat_q[`DCQ_STAT_NODATA] <= nd_r_q;
                end else if (wb_adr_i == `DCQ_LEVEL_OFS) begin
                    rdat_q[AW:0] <= lvl_w;
                end
            end
        end
    end

    // Unmapped addresses ack with zero data and ignore writes
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

endmodule // dcq_dual_clock_queue

// *** core/dcq_defines.vh ***
// Constants for the queue with watermark flags: register map, fields, reset values.
// Assumes inclusion by core/dcq_dual_clock_queue.v only; definitions, no logic.
`ifndef DCQ_DEFINES_VH
`define DCQ_DEFINES_VH

// Register byte offsets on the bus
`define DCQ_CTRL_OFS 4'h0
`define DCQ_STAT_OFS 4'h4
`define DCQ_LEVEL_OFS 4'h8

// Control fields
`define DCQ_CTRL_LOW_DUAL 0
`define DCQ_CTRL_HIGH_DUAL 1
`define DCQ_CTRL_DYNAMIC 2
`define DCQ_CTRL_W 3
`define DCQ_CTRL_RST 3'h0

// Status fields
`define DCQ_STAT_EMPTY 0
`define DCQ_STAT_LOW 1
`define DCQ_STAT_HIGH 2
`define DCQ_STAT_FULL 3
`define DCQ_STAT_NODATA 4

// Empty level is fixed
`define DCQ_EMPTY_LEVEL 0

`endif

// *** test/dcq_queue_props.sv ***
// Checker for queue flags, output stage and bus handshake.
// Assumes one clock and the queue built with its output stage.
`timescale 1ns/100ps
module dcq_queue_props #(parameter DW = 8) (
    // Clock and reset
    input logic clk_i,
    input logic rst_i,
    // Bus
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o,
    // Queue
    input logic push_enable_i,
    input logic output_stage_enable_i,
    input logic retransmit_pointer_clear_i,
    input logic [DW-1:0] pop_data_o,
    input logic empty_o,
    input logic low_water_o,
    input logic high_water_o,
    input logic full_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_reset_flags: assert property (disable iff (1'b0) rst_i |=> empty_o
        && low_water_o && !high_water_o && !full_o) else $error("flags wrong after reset");
    a_reset_stage: assert property (disable iff (1'b0) rst_i |=> pop_data_o == '0)
        else $error("output stage not cleared");
    a_stage_hold: assert property (!output_stage_enable_i |=> $stable(pop_data_o))
        else $error("output stage loaded while disabled");
    // Retransmit may refill, so the antecedent excludes it
    a_empty_hold: assert property (empty_o && !$past(push_enable_i)
        && !retransmit_pointer_clear_i && !$past(retransmit_pointer_clear_i) |=> empty_o)
        else $error("empty dropped without a push");
    a_push_fills: assert property (empty_o && push_enable_i |-> ##2 !empty_o)
        else $error("push not visible two cycles later");
    a_full_high: assert property (full_o |-> high_water_o)
        else $error("full without high water");
    a_empty_low: assert property (empty_o |-> low_water_o)
        else $error("empty without low water");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    c_full: cover property (full_o);
    c_refill: cover property (retransmit_pointer_clear_i ##2 !empty_o);
    c_first: cover property (empty_o ##1 !empty_o);
endmodule // dcq_queue_props

bind dcq_dual_clock_queue dcq_queue_props #(.DW(DW)) dcq_queue_props_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .push_enable_i(push_enable_i),
    .output_stage_enable_i(output_stage_enable_i),
    .retransmit_pointer_clear_i(retransmit_pointer_clear_i), .pop_data_o(pop_data_o),
    .empty_o(empty_o), .low_water_o(low_water_o), .high_water_o(high_water_o),
    .full_o(full_o));

// *** test/dcq_push_model.sv ***
// Push-side user model: streams count_i words from base_i upward.
// Assumes start_i is a one-cycle pulse while the model is idle.
`timescale 1ns/100ps
module dcq_push_model #(parameter DW = 8) (
    // Clock
    input logic clk_i,
    // Command
    input logic start_i,
    input logic [4:0] count_i,
    input logic [DW-1:0] base_i,
    // Push side
    output logic push_enable_o,
    output logic [DW-1:0] push_data_o
);
    logic [4:0] left_q = 5'h00;
    // Keeps pushing when full, so refusal gets exercised
    assign push_enable_o = left_q != 5'h00;
    // Idle data inverted so a stray capture shows
    assign push_data_o = push_enable_o ? base_i + DW'(count_i - left_q) : ~base_i;
    always @(posedge clk_i) begin
        if (start_i) begin
            left_q <= count_i;
        end else if (push_enable_o) begin
            left_q <= left_q - 5'h01;
        end
    end
endmodule // dcq_push_model

// *** test/tb.sv ***
// Bench for the queue: fill-level rows, stream, retransmit, hysteresis.
// Assumes the push model and the bound checker beside it.
`timescale 1ns/100ps
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_req = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
    logic wb_ack, pop_en = 1'b0, rtx = 1'b0, start = 1'b0;
    logic [4:0] cnt = 5'h00;
    logic [7:0] base = 8'h00, push_dat, pop_dat;
    logic push_en, empty, low, high, full;
    logic [3:0] lo_one = 4'h1, lo_set = 4'h1, lo_clr = 4'h3;
    logic [3:0] hi_one = 4'hE, hi_set = 4'hE, hi_clr = 4'hC, wb_sel = 4'hF;
    int fails = 0;
    int total_checks = 0;
    // Pushes, expected flags {full,high,low,empty}, expected level
    logic [12:0] rows [7] = '{{5'h00, 4'h3, 4'h0}, {5'h01, 4'h2, 4'h1}, {5'h02, 4'h0, 4'h2},
        {5'h0D, 4'h0, 4'hD}, {5'h0E, 4'h4, 4'hE}, {5'h0F, 4'hC, 4'hF}, {5'h11, 4'hC, 4'hF}};

    initial forever #50 clk_i = ~clk_i;

    dcq_dual_clock_queue #(.DW(8), .AW(4), .OUT_REG(1)) dcq_dual_clock_queue_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_req), .wb_stb_i(wb_req),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .push_enable_i(push_en),
        .push_data_i(push_dat), .pop_enable_i(pop_en), .output_stage_enable_i(pop_en),
        .retransmit_pointer_clear_i(rtx), .pop_data_o(pop_dat),
        .low_water_single_level_i(lo_one), .low_water_assert_level_i(lo_set),
        .low_water_release_level_i(lo_clr), .high_water_single_level_i(hi_one),
        .high_water_assert_level_i(hi_set), .high_water_release_level_i(hi_clr),
        .empty_o(empty), .low_water_o(low), .high_water_o(high), .full_o(full));

    dcq_push_model #(.DW(8)) dcq_push_model_inst (.clk_i(clk_i), .start_i(start),
        .count_i(cnt), .base_i(base), .push_enable_o(push_en), .push_data_o(push_dat));

    task automatic print_verdict();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        wb_req <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wd;
        @(posedge clk_i);
        while (wb_ack !== 1'b1) begin
            if (n == 20) begin
                fails++;
                print_verdict();
            end
            n++;
            @(posedge clk_i);
        end
        rd = wb_rdat;
        wb_req <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic push(input logic [4:0] n, input logic [7:0] b);
        start <= 1'b1;
        cnt <= n;
        base <= b;
        @(posedge clk_i);
        start <= 1'b0;
        repeat (n + 6) @(posedge clk_i);
    endtask

    // Output stage shares pop enable, so three enabled edges reach the port
    task automatic pop_run(input logic [4:0] n, input logic [7:0] b, input logic fresh);
        logic [4:0] idx;
        int first;
        idx = 5'h00;
        first = 0;
        pop_en <= 1'b1;
        for (int k = 1; k <= n + 4; k++) begin
            @(posedge clk_i);
            if (idx < n && pop_dat === b + 8'(idx)) begin
                if (idx == 5'h00) first = k;
                idx++;
            end
        end
        pop_en <= 1'b0;
        chk(idx, n);
        if (fresh) chk(first, 4);
        chk(pop_dat, b + 8'(n) - 8'h01);
    endtask

    initial begin
        do_reset();
        chk({full, high, low, empty}, 4'h3);
        chk(pop_dat, 8'h00);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 4'hC, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 7; i++) begin
            do_reset();
            push(rows[i][12:8], 8'h10);
            bus(1'b0, 4'h4, 32'h0);
            chk(rd[3:0], rows[i][7:4]);
            chk({full, high, low, empty}, rows[i][7:4]);
            bus(1'b0, 4'h8, 32'h0);
            chk(rd, rows[i][3:0]);
        end
        pop_run(5'h0F, 8'h10, 1'b1);
        @(posedge clk_i); // Pop idle one cycle first
        rtx <= 1'b1;
        @(posedge clk_i);
        rtx <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(empty, 1'b0);
        pop_run(5'h0F, 8'h10, 1'b0);
        do_reset();
        lo_set <= 4'h2; // Absolute fill levels
        lo_clr <= 4'h4;
        bus(1'b1, 4'h0, 32'h7);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h7);
        push(5'h03, 8'h40);
        chk({full, high, low, empty}, 4'h2);
        push(5'h01, 8'h43);
        chk({full, high, low, empty}, 4'h0);
        lo_one <= 4'h5;
        bus(1'b1, 4'h0, 32'h4);
        repeat (3) @(posedge clk_i);
        chk({full, high, low, empty}, 4'h2);
        print_verdict();
    end
endmodule // tb
